// [core/mcm_pkg.sv]
// constants for the module configuration memory (i2c descriptor store)
// Operation
// - location 0x0000 holds marker 0xAB
// - location 0x0006 holds zero
// - location 0x0007 holds CRC-8 over descriptor
// - blocks stored back to back from 0x0008
package mcm_pkg;
   // bus target address, 7 bits
   localparam logic [6:0] I2C_TARGET = 7'h50;
   // descriptor layout
   localparam logic [15:0] LOC_MARKER = 16'h0000;
   localparam logic [15:0] LOC_VENDOR = 16'h0001;
   localparam logic [15:0] LOC_PRODUCT = 16'h0002;
   localparam logic [15:0] LOC_VERSION = 16'h0003;
   localparam logic [15:0] LOC_RSVD_A = 16'h0004;
   localparam logic [15:0] LOC_COUNT = 16'h0005;
   localparam logic [15:0] LOC_RSVD_B = 16'h0006;
   localparam logic [15:0] LOC_CRC = 16'h0007;
   localparam logic [15:0] LOC_FIRST_BLOCK = 16'h0008;
   localparam int HDR_BYTES = 7;
   // fixed contents
   localparam logic [7:0] MARK_VALUE = 8'hab;
   localparam logic [7:0] RSVD_B_VALUE = 8'h00;
   localparam logic [7:0] UNMAPPED_VALUE = 8'hff;
   // crc-8 polynomial x^8+x^2+x+1 and start value
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [7:0] CRC_INIT = 8'h00;
   // block store: byte addresses 0x0008..0x00ff
   localparam int MEM_AW = 8;
   localparam int MEM_DEPTH = 256;
   // reset values and bits per byte
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // bus-side states
   typedef enum logic [3:0] {
      ST_IDLE, ST_DEV, ST_DEVACK, ST_PHI, ST_PHIACK, ST_PLO, ST_PLOACK,
      ST_WDAT, ST_RD, ST_RDACK
   } mcm_state_t;
endpackage : mcm_pkg

// [core/mcm_crc8.sv]
// one-byte update step of the descriptor crc-8
`timescale 1ns/1ps
module mcm_crc8
   import mcm_pkg::*;
(
   // running value in, byte in
   input wire logic [7:0] crcIn,
   input wire logic [7:0] dataIn,
   // updated value
   output logic [7:0] crcOut
);
   // msb-first shift, no reflection
   always_comb begin
      logic [7:0] c;
      c = crcIn ^ dataIn;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      crcOut = c;
   end
endmodule : mcm_crc8

// [core/mcm_store.sv]
// i2c target holding the module descriptor and its configuration blocks
`timescale 1ns/1ps
module mcm_store
   import mcm_pkg::*;
#(
   // identity bytes; values are arbitrary
   parameter logic [7:0] VENDOR_ID = 8'h01,
   parameter logic [7:0] PRODUCT_ID = 8'h02,
   parameter logic [7:0] VERSION_ID = 8'h03,
   parameter logic [7:0] RSVD_A_VALUE = 8'h00
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // i2c pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // block loading side
   input wire logic clearStore,
   input wire logic appendValid,
   input wire logic [7:0] appendData,
   input wire logic appendLast,
   output logic appendReady,
   output logic [7:0] blockCount
);
   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic sclMeta_q, sclSync_q, sclPrev_q; // scl stages
   logic sdaMeta_q, sdaSync_q, sdaPrev_q; // sda stages
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sclMeta_q <= 1'b1;
         sclSync_q <= 1'b1;
         sclPrev_q <= 1'b1;
         sdaMeta_q <= 1'b1;
         sdaSync_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclMeta_q <= sclIn;
         sclSync_q <= sclMeta_q;
         sclPrev_q <= sclSync_q;
         sdaMeta_q <= sdaIn;
         sdaSync_q <= sdaMeta_q;
         sdaPrev_q <= sdaSync_q;
      end
   end
   logic sclRise, sclFall, startSeen, stopSeen;
   assign sclRise = sclSync_q && !sclPrev_q;
   assign sclFall = !sclSync_q && sclPrev_q;
   // data moving while clock is high marks start or stop
   assign startSeen = sclSync_q && sclPrev_q && sdaPrev_q && !sdaSync_q;
   assign stopSeen = sclSync_q && sclPrev_q && !sdaPrev_q && sdaSync_q;

   ////////////////////////////////////////////////////////////////////////
   // block store and loader
   logic [7:0] mem [MEM_DEPTH]; // block bytes, indexed by byte address
   logic [MEM_AW-1:0] appPtr_q, appPtr_d; // next free byte
   logic [7:0] count_q, count_d; // complete blocks held
   logic full_q, full_d; // store has no room left
   logic ready_q, ready_d; // room flag as a flop, so the port leaves a register
   logic accept;
   assign accept = appendValid && !full_q;
   // loader next state
   always_comb begin
      appPtr_d = appPtr_q;
      count_d = count_q;
      full_d = full_q;
      if (clearStore) begin
         appPtr_d = LOC_FIRST_BLOCK[MEM_AW-1:0];
         count_d = COUNT_RESET;
         full_d = 1'b0;
      end else if (accept) begin
         // each byte lands right after the last one, so blocks abut
         appPtr_d = appPtr_q + 8'h01;
         if (appendLast) begin
            count_d = count_q + 8'h01;
         end
         full_d = (appPtr_q == 8'hff);
      end
      ready_d = !full_d;
   end
   // loader registers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         appPtr_q <= LOC_FIRST_BLOCK[MEM_AW-1:0];
         count_q <= COUNT_RESET;
         full_q <= 1'b0;
         ready_q <= 1'b1;
      end else begin
         appPtr_q <= appPtr_d;
         count_q <= count_d;
         full_q <= full_d;
         ready_q <= ready_d;
      end
   end
   // array write; no reset needed, unwritten bytes answer as unmapped
   always_ff @(posedge core_clk) begin
      if (accept && !clearStore) begin
         mem[appPtr_q] <= appendData;
      end
   end
   assign appendReady = ready_q;
   assign blockCount = count_q;

   ////////////////////////////////////////////////////////////////////////
   // descriptor header and its crc
   logic [7:0] hdr [HDR_BYTES];
   logic [7:0] crcChain [HDR_BYTES+1];
   assign hdr[0] = MARK_VALUE;
   assign hdr[1] = VENDOR_ID;
   assign hdr[2] = PRODUCT_ID;
   assign hdr[3] = VERSION_ID;
   assign hdr[4] = RSVD_A_VALUE;
   assign hdr[5] = count_q;
   assign hdr[6] = RSVD_B_VALUE;
   assign crcChain[0] = CRC_INIT;
   // crc follows the count live, so it is never stale after a load
   generate
      for (genvar g = 0; g < HDR_BYTES; g++) begin : gCrc
         mcm_crc8 uCrc (
            .crcIn(crcChain[g]),
            .dataIn(hdr[g]),
            .crcOut(crcChain[g+1])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // bus target state machine
   mcm_state_t state_q, state_d;
   logic [3:0] bitCnt_q, bitCnt_d; // bits moved in current byte
   logic [7:0] shift_q, shift_d; // in or out byte
   logic [15:0] ptr_q, ptr_d; // memory pointer
   logic isRead_q, isRead_d; // direction of current transfer
   logic oe_q, oe_d; // pulling sda low
   logic [7:0] rdByte; // byte at pointer
   logic loadNow; // a read byte is fetched this cycle
   // byte lookup: header, stored blocks, else unmapped
   always_comb begin
      rdByte = UNMAPPED_VALUE;
      if (ptr_q == LOC_CRC) begin
         // checksum lies past the last header byte, outside the header array
         rdByte = crcChain[HDR_BYTES];
      end else if (ptr_q < LOC_CRC) begin
         rdByte = hdr[ptr_q[2:0]];
      end else if (ptr_q[15:8] == 8'h00 && (full_q || ptr_q[7:0] < appPtr_q)) begin
         rdByte = mem[ptr_q[7:0]];
      end
   end
   // next state
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      isRead_d = isRead_q;
      oe_d = oe_q;
      loadNow = 1'b0;
      if (startSeen) begin
         state_d = ST_DEV;
         bitCnt_d = 4'h0;
         oe_d = 1'b0;
      end else if (stopSeen) begin
         state_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_DEV, ST_PHI, ST_PLO, ST_WDAT: begin
               if (sclRise) begin
                  shift_d = {shift_q[6:0], sdaSync_q};
                  bitCnt_d = bitCnt_q + 4'h1;
               end else if (sclFall && bitCnt_q == BITS_PER_BYTE) begin
                  bitCnt_d = 4'h0;
                  oe_d = 1'b1;
                  if (state_q == ST_DEV) begin
                     // only our address is acknowledged
                     if (shift_q[7:1] == I2C_TARGET) begin
                        state_d = ST_DEVACK;
                        isRead_d = shift_q[0];
                     end else begin
                        state_d = ST_IDLE;
                        oe_d = 1'b0;
                     end
                  end else if (state_q == ST_PHI) begin
                     state_d = ST_PHIACK;
                     ptr_d = {shift_q, ptr_q[7:0]};
                  end else if (state_q == ST_PLO) begin
                     state_d = ST_PLOACK;
                     ptr_d = {ptr_q[15:8], shift_q};
                  end else begin
                     // content is read-only from the bus: data is refused
                     state_d = ST_IDLE;
                     oe_d = 1'b0;
                  end
               end
            end
            ST_DEVACK, ST_PHIACK, ST_PLOACK: begin
               if (sclFall) begin
                  oe_d = 1'b0;
                  if (state_q == ST_DEVACK && isRead_q) begin
                     loadNow = 1'b1;
                  end else if (state_q == ST_DEVACK) begin
                     state_d = ST_PHI;
                  end else if (state_q == ST_PHIACK) begin
                     state_d = ST_PLO;
                  end else begin
                     state_d = ST_WDAT;
                  end
               end
            end
            ST_RD: begin
               if (sclFall) begin
                  if (bitCnt_q == BITS_PER_BYTE) begin
                     // release for the reader's acknowledge
                     oe_d = 1'b0;
                     state_d = ST_RDACK;
                     ptr_d = ptr_q + 16'h0001;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = !shift_q[6];
                     bitCnt_d = bitCnt_q + 4'h1;
                  end
               end
            end
            ST_RDACK: begin
               if (sclRise && sdaSync_q) begin
                  state_d = ST_IDLE; // not acknowledged: reader is done
               end else if (sclFall) begin
                  loadNow = 1'b1;
               end
            end
         endcase
         if (loadNow) begin
            // first bit goes out on the same falling edge
            state_d = ST_RD;
            shift_d = rdByte;
            oe_d = !rdByte[7];
            bitCnt_d = 4'h1;
         end
      end
   end
   // bus registers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= PTR_RESET;
         isRead_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         isRead_q <= isRead_d;
         oe_q <= oe_d;
      end
   end
   // open drain: only ever pulls low
   logic sdaLow_q;
   always_ff @(posedge core_clk) begin
      sdaLow_q <= 1'b0;
   end
   assign sdaOut = sdaLow_q;
   assign sdaOe = oe_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_marker_read: assert property (loadNow && ptr_q == LOC_MARKER |=> shift_q == 8'hab)
      else $error("marker byte not served at location zero");
   a_rsvd_zero: assert property (loadNow && ptr_q == LOC_RSVD_B |=> shift_q == 8'h00)
      else $error("reserved location six not zero");
   a_crc_served: assert property (loadNow && ptr_q == LOC_CRC |=> shift_q == crcChain[7])
      else $error("crc byte does not match descriptor");
   a_first_block: assert property (clearStore |=> appPtr_q == 8'h08 && count_q == 8'h00)
      else $error("first block not placed at location eight");
   a_back_to_back: assert property (accept && !clearStore |=> appPtr_q == $past(appPtr_q) + 8'h01)
      else $error("stored bytes not contiguous");
   a_addr_ack: assert property (sclFall && state_q == ST_DEV && bitCnt_q == 4'h8 && shift_q[7:1] != 7'h50 && !startSeen && !stopSeen |=> state_q == ST_IDLE && !oe_q)
      else $error("foreign target address acknowledged");
   c_header_read: cover property (loadNow && ptr_q == LOC_CRC);
   c_block_read: cover property (loadNow && ptr_q == LOC_FIRST_BLOCK);
   c_store_full: cover property (full_q);
endmodule : mcm_store

// [bench/mcm_reader_model.sv]
// i2c reader model: fetches store bytes and walks the configuration blocks
`timescale 1ns/1ps
module mcm_reader_model
   import mcm_pkg::*;
(
   // pins of the store
   output logic sclIn,
   output logic sdaIn,
   input wire logic sdaOe
);
   logic mLow; // reader pulls data low
   logic nackSeen; // a byte of ours was refused
   logic errFlag; // marker or checksum wrong
   logic [23:0] idWord; // vendor, product, version
   logic [7:0] rx[$]; // bytes of the last read
   int nBlk; // blocks walked
   int endAt; // address after the last block
   // open drain: pulled up unless someone pulls low
   assign sdaIn = ~(mLow | sdaOe);
   // clock stands high between frames
   initial begin
      sclIn = 1'b1;
      mLow = 1'b0;
   end
   // one bit: data set in the low phase, sampled in the middle of the high phase;
   // pins move by non-blocking assignment so the store never races its edge
   task automatic bitIo(input logic b, output logic r);
      mLow <= ~b;
      #40;
      sclIn <= 1'b1;
      #40;
      r = sdaIn;
      #40;
      sclIn <= 1'b0;
      #40;
   endtask : bitIo
   // start or repeated start; stop
   task automatic startCond();
      mLow <= 1'b0;
      #40;
      sclIn <= 1'b1;
      #40;
      mLow <= 1'b1;
      #40;
      sclIn <= 1'b0;
      #40;
   endtask : startCond
   task automatic stopCond();
      mLow <= 1'b1;
      #40;
      sclIn <= 1'b1;
      #40;
      mLow <= 1'b0;
      #40;
   endtask : stopCond
   // byte out, then the target's acknowledge
   task automatic wrByte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitIo(b[i], r);
      end
      bitIo(1'b1, r);
      if (r) begin
         nackSeen = 1'b1;
      end
   endtask : wrByte
   // byte in; the last one is refused so the target lets go
   task automatic rdByte(input logic last);
      logic r;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         bitIo(1'b1, r);
         d = {d[6:0], r};
      end
      rx.push_back(d);
      bitIo(last, r);
   endtask : rdByte
   // set the pointer, then read n bytes
   task automatic readAt(input logic [15:0] ptr, input int n);
      rx.delete();
      nackSeen = 1'b0;
      startCond();
      wrByte({I2C_TARGET, 1'b0});
      wrByte(ptr[15:8]);
      wrByte(ptr[7:0]);
      startCond();
      wrByte({I2C_TARGET, 1'b1});
      for (int i = 0; i < n; i++) begin
         rdByte(i == n - 1);
      end
      stopCond();
   endtask : readAt
   // address byte plus a few data bytes, for refusal tests
   task automatic probe(input logic [7:0] a, input int extra);
      nackSeen = 1'b0;
      startCond();
      wrByte(a);
      for (int i = 0; i < extra; i++) begin
         wrByte(8'h00);
      end
      stopCond();
   endtask : probe
   // crc-8 step, msb first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8
   // reader's walk: check, identify, then blocks in stored order
   task automatic walk();
      logic [7:0] c;
      int cnt;
      int sa;
      readAt(LOC_MARKER, HDR_BYTES + 1);
      c = CRC_INIT;
      for (int i = 0; i < HDR_BYTES; i++) begin
         c = crc8(c, rx[i]);
      end
      errFlag = (rx[0] !== MARK_VALUE) || (c !== rx[7]);
      idWord = {rx[1], rx[2], rx[3]}; // byte 4 skipped
      cnt = int'(rx[5]); // zero skips the loop
      sa = LOC_FIRST_BLOCK;
      nBlk = 0;
      // nothing applied after an error; one block fully before the next
      for (int b = 0; b < cnt && !errFlag; b++) begin
         readAt(sa[15:0], 3);
         nBlk++;
         if (rx[0][7:4] == 4'h2) begin
            #(1000000 * int'({rx[0][3:0], rx[1]})); // delay in ms
         end else begin
            sa = sa + int'({rx[0][3:0], rx[1]}); // crc byte counted
         end
         sa = sa + 3;
      end
      endAt = sa;
   endtask : walk
endmodule : mcm_reader_model

// [bench/mcm_store_tb.sv]
// self-checking bench: descriptor store read by an i2c reader model
`timescale 1ns/1ps
module mcm_store_tb
   import mcm_pkg::*;
();
   logic core_clk;
   logic reset_n;
   logic sclIn;
   logic sdaIn;
   logic sdaOe;
   logic sdaOut;
   logic clearStore;
   logic appendValid;
   logic [7:0] appendData;
   logic appendLast;
   logic appendReady;
   logic [7:0] blockCount;
   logic [7:0] st[$]; // bytes the store should hold
   logic [7:0] img[$]; // expected memory image
   int nb; // expected block count
   int n_errors;
   int checks_done;
   longint t0; // start time of a walk
   int unsigned seed = 66;
   ////////////////////////////////////////////////////////////////////
   // identity bytes are arbitrary values
   mcm_store #(.VENDOR_ID(8'h3c), .PRODUCT_ID(8'h5a), .VERSION_ID(8'h96),
      .RSVD_A_VALUE(8'h77)) uut (.core_clk(core_clk), .reset_n(reset_n),
      .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .clearStore(clearStore), .appendValid(appendValid), .appendData(appendData),
      .appendLast(appendLast), .appendReady(appendReady), .blockCount(blockCount));
   mcm_reader_model rm (.sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe));
   ////////////////////////////////////////////////////////////////////
   // xorshift source
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   // expected image: descriptor, live checksum, stored bytes
   function automatic void mkImg();
      logic [7:0] c;
      img = {MARK_VALUE, 8'h3c, 8'h5a, 8'h96, 8'h77, nb[7:0], RSVD_B_VALUE};
      c = CRC_INIT;
      foreach (img[i]) c = rm.crc8(c, img[i]);
      img = {img, c, st};
   endfunction : mkImg
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      checks_done++;
      if (got !== want) begin
         n_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   // read n bytes from a and compare with the image
   task automatic readCmp(input int a, input int n);
      mkImg();
      rm.readAt(a[15:0], n);
      chk({7'h0, rm.nackSeen}, 8'h00);
      for (int i = 0; i < n; i++) begin
         chk(rm.rx[i], (a + i < img.size()) ? img[a + i] : UNMAPPED_VALUE);
      end
   endtask : readCmp
   // offer a byte; a full store drops it
   task automatic push(input logic [7:0] d, input logic last);
      @(posedge core_clk);
      appendValid <= 1'b1;
      appendData <= d;
      appendLast <= last;
      if (st.size() < MEM_DEPTH - 8) begin
         st.push_back(d);
         nb += last;
      end
   endtask : push
   task automatic idle();
      @(posedge core_clk);
      appendValid <= 1'b0;
      appendLast <= 1'b0;
      clearStore <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : idle
   task automatic summarize();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // cut a hang short
   initial begin
      repeat (100000) @(posedge core_clk);
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
   end
   initial begin
      reset_n = 1'b0;
      clearStore = 1'b0;
      appendValid = 1'b0;
      appendData = 8'h00;
      appendLast = 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(blockCount, 8'h00);
      chk({5'h0, appendReady, sdaOe, sdaOut}, 8'h04);
      readCmp(0, 9); // empty store
      // three blocks: plain, checksummed, delay of 1 ms
      push(8'h00, 0);
      push(8'h03, 0);
      for (int i = 0; i < 4; i++) push(rnd(), i == 3);
      push(8'h10, 0);
      push(8'h02, 0);
      for (int i = 0; i < 3; i++) push(rnd(), i == 2);
      push(8'h20, 0);
      push(8'h01, 0);
      push(rnd(), 1);
      idle();
      chk(blockCount, 8'h03);
      readCmp(0, 23);
      t0 = $time;
      rm.walk();
      chk({7'h0, ($time - t0) >= 64'd1000000}, 8'h01);
      chk({rm.errFlag, rm.nBlk[6:0]}, 8'h03);
      chk(rm.endAt[7:0], 8'h16);
      chk(rm.idWord[23:16], 8'h3c);
      chk(rm.idWord[15:8], 8'h5a);
      chk(rm.idWord[7:0], 8'h96);
      rm.probe({7'h51, 1'b0}, 0);
      chk({7'h0, rm.nackSeen}, 8'h01);
      rm.probe({I2C_TARGET, 1'b0}, 3);
      chk({7'h0, rm.nackSeen}, 8'h01);
      readCmp(5, 1);
      // fill until refused, then clear while offering bytes
      for (int i = 0; i < 240; i++) push(rnd(), 0);
      idle();
      chk({7'h0, appendReady}, 8'h00);
      readCmp(16'h00fe, 3);
      for (int k = 0; k < 2; k++) begin
         @(posedge core_clk);
         clearStore <= 1'b1;
         appendValid <= 1'b1;
         appendLast <= 1'b1;
         st.delete();
         nb = 0;
         idle();
         chk({appendReady, blockCount[6:0]}, 8'h80);
      end
      readCmp(0, 9);
      // an empty store must walk no block at all
      rm.walk();
      chk({rm.errFlag, rm.nBlk[6:0]}, 8'h00);
      chk(rm.endAt[7:0], 8'h08);
      summarize();
   end
endmodule : mcm_store_tb
